// file: core/ebc_ctrl.sv
// External bus strobe, expanded RAM mapping and emulation entry control.
// Assumes APB master, pins sampled on pclk, reset_pin is the device reset pin.
//
// Behaviour
// R1: Emulation is requested by holding the latch strobe pin low during reset while program strobe is high.
// R2: The latch strobe pin held low through reset release enters emulation instead of normal run.
// R3: In emulation the latch, program strobe and ports 1-3 are pulled up, port 0 and two-wire pins float, oscillators run.
// R4: Emulation ends only on an ordinary reset without the entry sequence.
// R5: The latch strobe demultiplexes port 0 for external accesses and also runs during internal execution.
// R6: With suppression clear the latch strobe runs freely at 1/6 of the clock, 1/3 in double speed.
// R7: With suppression set the latch strobe appears only for data moves, code table reads and external fetches.
// R8: While suppressed the latch pin is not driven and is weakly pulled high.
// R9: The stretch bit sets read and write strobes to 6 clocks when clear and 30 when set.
// R10: The two size bits select 256, 512, 768 or 1024 bytes of expanded RAM.
// R11: The external select bit routes pointer data moves to internal RAM when clear, external when set.
// R12: The external select bit is loaded from the security byte after power-up, internal by default.
// R13: Reserved bits 7, 6 and 4 read as undefined and must not be written to one.
// R14: The RAM configuration bit of the security byte inhibits the internal expanded RAM when programmed.
// R15: Double speed runs six clocks per instruction cycle, setting the faster latch strobe rate.
// R16: Reset loads stretch clear, size 00, suppression clear and the external select from the security byte.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module ebc_ctrl
    import ebc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        reset_pin,
    input  wire logic        latch_strobe_in,
    input  wire logic        program_store_strobe_in,
    input  wire logic        double_speed_mode,
    input  wire logic        security_ext_ram,
    input  wire logic        security_ram_inhibit,
    input  wire logic        xmove_req,
    input  wire logic        xmove_write,
    input  wire logic [15:0] xmove_addr,
    input  wire logic        code_table_read,
    input  wire logic        ext_fetch,
    output logic             latch_strobe,
    output logic             latch_strobe_oe,
    output logic             read_strobe_n,
    output logic             write_strobe_n,
    output logic             xmove_external,
    output logic             xmove_internal,
    output logic             emulation_active,
    output ebc_pins_s        pin_state
);
    ebc_emul_e   em_r;
    ebc_emul_e   em_nxt;
    logic        suppress_r;
    logic        stretch_r;
    logic [1:0]  ram_size_r;
    logic        external_ram_select_r;
    logic        hsb_loaded_r;
    logic        hold;
    logic        route_ext;
    logic        strobe_busy;
    logic        bus_req;
    logic        wr_en;
    logic [7:0]  aux_rd;
    logic [10:0] ram_limit;

    // Emulation entry sequence
    always_comb begin
        em_nxt = em_r;
        case (em_r)
            EM_RUN, EM_EMUL: begin
                if (reset_pin) begin
                    em_nxt = (!latch_strobe_in && program_store_strobe_in) ? EM_ARM : EM_PLAIN; // R1
                end
            end
            EM_ARM: begin
                if (reset_pin) begin
                    em_nxt = latch_strobe_in ? EM_PLAIN : EM_ARM;
                end else begin
                    em_nxt = latch_strobe_in ? EM_RUN : EM_EMUL; // R2
                end
            end
            EM_PLAIN: begin
                if (reset_pin) begin
                    em_nxt = (!latch_strobe_in && program_store_strobe_in) ? EM_ARM : EM_PLAIN;
                end else begin
                    em_nxt = EM_RUN; // R4
                end
            end
            default: em_nxt = EM_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            em_r <= EM_RUN;
        end else begin
            em_r <= em_nxt;
        end
    end

    // Counts the entry cycle too, so the latch pin is released as emulation starts
    assign hold = (em_nxt == EM_EMUL) || reset_pin; // R3

    // Pin states; while the device is held in reset the latch pin is left to the outside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_state        <= '0;
            emulation_active <= 1'b0;
        end else begin
            emulation_active <= (em_nxt == EM_EMUL);
            pin_state.ale_pu  <= (em_nxt == EM_EMUL) || (suppress_r && !bus_req); // R3 R8
            pin_state.program_store_strobe_pu <= (em_nxt == EM_EMUL); // R3
            pin_state.p1_pu   <= (em_nxt == EM_EMUL);
            pin_state.p2_pu   <= (em_nxt == EM_EMUL);
            pin_state.p3_pu   <= (em_nxt == EM_EMUL);
            pin_state.p0_flt  <= (em_nxt == EM_EMUL);
            pin_state.twi_flt <= (em_nxt == EM_EMUL);
            pin_state.osc_run <= 1'b1;
        end
    end

    // APB slave: one access cycle, no wait states
    assign wr_en = psel && penable && pready && pwrite && (paddr == EBC_AUX_ADDR);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (paddr != EBC_AUX_ADDR);
            if (psel && !penable && !pwrite && paddr == EBC_AUX_ADDR) begin
                prdata <= {24'h00_0000, aux_rd};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Reserved bits read as zero and ignore writes
    always_comb begin
        aux_rd                  = 8'h00; // R13
        aux_rd[EBC_BIT_SUPPRESS] = suppress_r;
        aux_rd[EBC_BIT_EXTERNAL_RAM_SELECT]   = external_ram_select_r;
        aux_rd[EBC_BIT_SIZE_LO]  = ram_size_r[0];
        aux_rd[EBC_BIT_SIZE_HI]  = ram_size_r[1];
        aux_rd[EBC_BIT_STRETCH]  = stretch_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            suppress_r <= EBC_RST_SUPPRESS;
            stretch_r  <= EBC_RST_STRETCH;
            ram_size_r <= EBC_RST_SIZE;
        end else if (reset_pin) begin
            suppress_r <= EBC_RST_SUPPRESS; // R16
            stretch_r  <= EBC_RST_STRETCH;
            ram_size_r <= EBC_RST_SIZE;
        end else if (wr_en) begin
            suppress_r <= pwdata[EBC_BIT_SUPPRESS]; // R7
            stretch_r  <= pwdata[EBC_BIT_STRETCH]; // R9
            ram_size_r <= {pwdata[EBC_BIT_SIZE_HI], pwdata[EBC_BIT_SIZE_LO]}; // R10
        end
    end

    // External select follows the security byte after power-up and each reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            external_ram_select_r     <= EBC_RST_EXTERNAL_RAM_SELECT;
            hsb_loaded_r <= 1'b0;
        end else if (!hsb_loaded_r || reset_pin) begin
            external_ram_select_r     <= security_ext_ram; // R12 R16
            hsb_loaded_r <= 1'b1;
        end else if (wr_en) begin
            external_ram_select_r <= pwdata[EBC_BIT_EXTERNAL_RAM_SELECT]; // R11
        end
    end

    // Data move routing
    assign ram_limit = ebc_ram_limit(ram_size_r); // R10
    assign route_ext = external_ram_select_r || security_ram_inhibit || ({5'h00, xmove_addr[10:0]} != xmove_addr)
                       || (xmove_addr[10:0] >= ram_limit); // R11 R14

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xmove_external <= 1'b0;
            xmove_internal <= 1'b0;
        end else begin
            xmove_external <= xmove_req && !hold && route_ext;
            xmove_internal <= xmove_req && !hold && !route_ext;
        end
    end

    assign bus_req = strobe_busy || (xmove_req && route_ext) || code_table_read || ext_fetch; // R7

    ebc_strobe u_strobe (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (xmove_req && !hold && route_ext),
        .write   (xmove_write),
        .stretch (stretch_r),
        .rd_n    (read_strobe_n),
        .wr_n    (write_strobe_n),
        .busy    (strobe_busy)
    );

    ebc_ale u_ale (
        .pclk         (pclk),
        .presetn      (presetn),
        .double_speed (double_speed_mode),
        .suppress     (suppress_r),
        .bus_req      (bus_req),
        .hold         (hold),
        .ale          (latch_strobe),
        .ale_oe       (latch_strobe_oe)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_entry;
        reset_pin && !latch_strobe_in && program_store_strobe_in ##1 !reset_pin && !latch_strobe_in;
    endsequence
    property p_entry;
        s_entry |=> emulation_active && pin_state.p0_flt && pin_state.p1_pu;
    endproperty
    a_entry: assert property (p_entry) else $error("emulation not entered"); // R2
    property p_emul_pins;
        emulation_active |-> pin_state.ale_pu && pin_state.program_store_strobe_pu && pin_state.twi_flt
                             && pin_state.osc_run && !latch_strobe_oe;
    endproperty
    a_emul_pins: assert property (p_emul_pins) else $error("emulation pin state wrong"); // R3
    sequence s_plain_reset;
        reset_pin && latch_strobe_in ##1 !reset_pin;
    endsequence
    property p_exit;
        s_plain_reset |=> !emulation_active;
    endproperty
    a_exit: assert property (p_exit) else $error("emulation not left on plain reset"); // R4
    property p_stay;
        emulation_active && !reset_pin |=> emulation_active;
    endproperty
    a_stay: assert property (p_stay) else $error("emulation left without reset"); // R4
    property p_defaults;
        reset_pin |=> !stretch_r && ram_size_r == 2'h0 && !suppress_r
                      && external_ram_select_r == $past(security_ext_ram);
    endproperty
    a_defaults: assert property (p_defaults) else $error("reset defaults not loaded"); // R16
    property p_write_aux;
        wr_en && !reset_pin |=> stretch_r == $past(pwdata[EBC_BIT_STRETCH])
                                && ram_size_r == $past(pwdata[3:2]);
    endproperty
    a_write_aux: assert property (p_write_aux) else $error("aux write lost"); // R9
    property p_route_int;
        xmove_req && !hold && !external_ram_select_r && !security_ram_inhibit && xmove_addr < 16'h0100
        |=> xmove_internal && !xmove_external;
    endproperty
    a_route_int: assert property (p_route_int) else $error("internal move misrouted"); // R11
    property p_inhibit;
        xmove_req && !hold && security_ram_inhibit |=> xmove_external;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibited RAM still used"); // R14
    property p_reserved;
        pready && psel && !pwrite && !pslverr |-> prdata[7:6] == 2'h0 && !prdata[4];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // R13
    property p_route_ext;
        xmove_req && !hold && external_ram_select_r |=> xmove_external && !xmove_internal;
    endproperty
    a_route_ext: assert property (p_route_ext) else $error("external move misrouted"); // R11
    property p_size_in;
        xmove_req && !hold && !external_ram_select_r && !security_ram_inhibit
        && xmove_addr[15:8] <= {6'h00, ram_size_r} |=> xmove_internal && !xmove_external;
    endproperty
    a_size_in: assert property (p_size_in) else $error("move inside RAM size sent out"); // R10
    property p_size_out;
        xmove_req && !hold && xmove_addr[15:8] > {6'h00, ram_size_r}
        |=> xmove_external && !xmove_internal;
    endproperty
    a_size_out: assert property (p_size_out) else $error("move beyond RAM size kept in"); // R10
    property p_write_ext;
        wr_en && !reset_pin && hsb_loaded_r |=> external_ram_select_r == $past(pwdata[EBC_BIT_EXTERNAL_RAM_SELECT]);
    endproperty
    a_write_ext: assert property (p_write_ext) else $error("external select write lost"); // R11
    property p_emul_quiet;
        emulation_active |=> !latch_strobe && !xmove_external && !xmove_internal;
    endproperty
    a_emul_quiet: assert property (p_emul_quiet) else $error("bus active in emulation"); // R3
    property p_reset_quiet;
        reset_pin |=> !latch_strobe && !latch_strobe_oe && !xmove_external && !xmove_internal;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("latch pin driven in reset"); // R1
    property p_pullup;
        suppress_r && !bus_req |=> pin_state.ale_pu && !latch_strobe_oe;
    endproperty
    a_pullup: assert property (p_pullup) else $error("suppressed latch pin not pulled up"); // R8
    property p_plain_pins;
        !emulation_active |-> !pin_state.program_store_strobe_pu && !pin_state.p0_flt && !pin_state.twi_flt;
    endproperty
    a_plain_pins: assert property (p_plain_pins) else $error("emulation pins outside emulation"); // R4
endmodule

// file: core/ebc_pkg.sv
// Package for the external bus strobe and emulation control block.
// Assumes a single 25 MHz clock (40 ns) standing in for the oscillator.
package ebc_pkg;
    // Auxiliary register: printed offset is not word aligned, so it is an index
    localparam logic [11:0] EBC_AUX_IDX       = 12'h08e;
    localparam logic [11:0] EBC_AUX_ADDR      = 12'(EBC_AUX_IDX * 4);
    localparam int          EBC_BIT_SUPPRESS  = 0;
    localparam int          EBC_BIT_EXTERNAL_RAM_SELECT    = 1;
    localparam int          EBC_BIT_SIZE_LO   = 2;
    localparam int          EBC_BIT_SIZE_HI   = 3;
    localparam int          EBC_BIT_STRETCH   = 5;
    localparam logic        EBC_RST_SUPPRESS  = 1'b0;
    localparam logic        EBC_RST_STRETCH   = 1'b0;
    localparam logic [1:0]  EBC_RST_SIZE      = 2'h0;
    localparam logic        EBC_RST_EXTERNAL_RAM_SELECT    = 1'b0;
    // Latch strobe divider: 1/6 standard, 1/3 double speed
    localparam logic [4:0]  EBC_ALE_DIV_STD   = 5'h06;
    localparam logic [4:0]  EBC_ALE_DIV_X2    = 5'h03;
    // Read and write strobe lengths in clock periods
    localparam logic [4:0]  EBC_STB_SHORT     = 5'h06;
    localparam logic [4:0]  EBC_STB_LONG      = 5'h1e;
    // Expanded RAM size step in bytes
    localparam logic [10:0] EBC_RAM_STEP      = 11'h100;

    typedef enum logic [1:0] {
        EM_RUN   = 2'b00,
        EM_ARM   = 2'b01,
        EM_PLAIN = 2'b10,
        EM_EMUL  = 2'b11
    } ebc_emul_e;

    // Pin state controls; pu = weak pull-up, flt = float, run = oscillator on
    typedef struct packed {
        logic ale_pu;
        logic program_store_strobe_pu;
        logic p1_pu;
        logic p2_pu;
        logic p3_pu;
        logic p0_flt;
        logic twi_flt;
        logic osc_run;
    } ebc_pins_s;

    function automatic logic [10:0] ebc_ram_limit(input logic [1:0] size);
        ebc_ram_limit = 11'(EBC_RAM_STEP * ({9'h000, size} + 11'h001));
    endfunction
endpackage

// file: core/ebc_ale.sv
// Address-latch strobe generator with free-running and on-demand modes.
// Assumes pclk is the oscillator clock and bus_req marks external accesses.
`timescale 1ns/1ps
module ebc_ale
    import ebc_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic double_speed,
    input  wire logic suppress,
    input  wire logic bus_req,
    input  wire logic hold,
    output logic      ale,
    output logic      ale_oe
);
    logic [4:0] cnt_r;
    logic       tick;
    logic [4:0] div;

    assign div  = double_speed ? EBC_ALE_DIV_X2 : EBC_ALE_DIV_STD;
    assign tick = (cnt_r == 5'h00);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 5'h00;
        end else if (tick || cnt_r >= div) begin
            cnt_r <= div - 5'h01; // R6 R15
        end else begin
            cnt_r <= cnt_r - 5'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ale    <= 1'b0;
            ale_oe <= 1'b0;
        end else begin
            ale    <= tick && !hold && (!suppress || bus_req); // R5 R6 R7
            ale_oe <= !hold && (!suppress || bus_req); // R8
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_std;
        !suppress && !hold && !double_speed;
    endsequence
    // Rate is measured from a strobe whose divider reload saw the same speed
    sequence s_std_run;
        !double_speed ##1 (ale && !suppress && !hold && !double_speed);
    endsequence
    property p_std_rate;
        s_std_run ##1 s_std [*5] |=> ale;
    endproperty
    a_std_rate: assert property (p_std_rate) else $error("latch strobe not 1/6"); // R6
    sequence s_x2;
        !suppress && !hold && double_speed;
    endsequence
    sequence s_x2_run;
        double_speed ##1 (ale && !suppress && !hold && double_speed);
    endsequence
    property p_x2_rate;
        s_x2_run ##1 s_x2 [*2] |=> ale && !$past(ale) && !$past(ale, 2);
    endproperty
    a_x2_rate: assert property (p_x2_rate) else $error("latch strobe not 1/3"); // R15
    property p_quiet;
        suppress && !bus_req |=> !ale && !ale_oe;
    endproperty
    a_quiet: assert property (p_quiet) else $error("suppressed strobe still driven"); // R8
endmodule

// file: core/ebc_strobe.sv
// Read and write strobe timer for external data moves.
// Assumes start is a one-cycle pulse and is ignored while busy.
`timescale 1ns/1ps
module ebc_strobe
    import ebc_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic start,
    input  wire logic write,
    input  wire logic stretch,
    output logic      rd_n,
    output logic      wr_n,
    output logic      busy
);
    logic [4:0] cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 5'h00;
            rd_n  <= 1'b1;
            wr_n  <= 1'b1;
            busy  <= 1'b0;
        end else if (start && !busy) begin
            cnt_r <= (stretch ? EBC_STB_LONG : EBC_STB_SHORT) - 5'h01; // R9
            rd_n  <= write;
            wr_n  <= !write;
            busy  <= 1'b1;
        end else if (busy && cnt_r != 5'h00) begin
            cnt_r <= cnt_r - 5'h01;
        end else begin
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            busy <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_short;
        start && !busy && !stretch && !write |=> !rd_n [*6] ##1 rd_n;
    endproperty
    a_short: assert property (p_short) else $error("short read strobe not 6 cycles"); // R9
    property p_long;
        start && !busy && stretch && write |=> !wr_n ##29 !wr_n ##1 wr_n;
    endproperty
    a_long: assert property (p_long) else $error("long write strobe not 30 cycles"); // R9
endmodule

// file: sim/ebc_ext_party.sv
// Model of the party beside the latch strobe and program strobe pins.
// Assumes emu_req changes just after a pclk edge, set by the bench.
`timescale 1ns/1ps
module ebc_ext_party (
    input  wire logic emu_req,
    input  wire logic latch_strobe,
    input  wire logic latch_strobe_oe,
    output logic      latch_strobe_in,
    output logic      program_store_strobe_in
);
    // Device drive wins; else the party pulls low on request; else weak pull-up
    assign latch_strobe_in = latch_strobe_oe ? latch_strobe : !emu_req;
    // Program strobe stays high while the party idles
    assign program_store_strobe_in = 1'b1;
endmodule

// file: sim/ebc_ctrl_test.sv
// Testbench for the external bus strobe and emulation control block.
// Assumes the APB slave answers in the cycle after setup.
`timescale 1ns/1ps
module ebc_ctrl_test
    import ebc_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_d;
    logic        reset_pin, lat_in, pss_in, dbl, sec_ext, sec_inh, emu_req;
    logic        xreq, xwr, cread, efetch, lat, lat_oe, rd_n, wr_n, x_ext, x_int, emu;
    logic [15:0] xaddr;
    ebc_pins_s   pins;
    int          num_errors, n_checks, c, nl, ne, ni;

    ebc_ctrl u_ebc_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reset_pin(reset_pin),
        .latch_strobe_in(lat_in), .program_store_strobe_in(pss_in),
        .double_speed_mode(dbl), .security_ext_ram(sec_ext),
        .security_ram_inhibit(sec_inh), .xmove_req(xreq), .xmove_write(xwr),
        .xmove_addr(xaddr), .code_table_read(cread), .ext_fetch(efetch),
        .latch_strobe(lat), .latch_strobe_oe(lat_oe), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .xmove_external(x_ext), .xmove_internal(x_int),
        .emulation_active(emu), .pin_state(pins));

    ebc_ext_party u_ebc_ext_party (.emu_req(emu_req), .latch_strobe(lat),
        .latch_strobe_oe(lat_oe), .latch_strobe_in(lat_in),
        .program_store_strobe_in(pss_in));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One APB transfer; held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd_d = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic count_ale(input int cyc);
        c = 0;
        repeat (cyc) begin
            @(posedge pclk);
            if (lat === 1'b1) c++;
        end
    endtask

    // Data move; counts strobe-low cycles and route pulses over a fixed window
    task automatic move(input logic [15:0] a, input logic w);
        @(posedge pclk);
        xreq <= 1'b1;
        xaddr <= a;
        xwr <= w;
        @(posedge pclk);
        xreq <= 1'b0;
        nl = 0;
        ne = 0;
        ni = 0;
        repeat (40) begin
            @(posedge pclk);
            if ((w ? wr_n : rd_n) === 1'b0) nl++;
            if (x_ext === 1'b1) ne++;
            if (x_int === 1'b1) ni++;
        end
    endtask

    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        conclude();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, reset_pin, dbl} = '0;
        {sec_ext, sec_inh, emu_req, xreq, xwr, xaddr, cread, efetch} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, EBC_AUX_ADDR, 32'h0);
        check(rd_d, 32'h0);
        apb(1, EBC_AUX_ADDR, 32'h2f);
        apb(0, EBC_AUX_ADDR, 32'h0);
        check(rd_d, 32'h2f);
        apb(1, EBC_AUX_ADDR, 32'h0);
        apb(0, 12'h000, 32'h0);
        check({rd_d[30:0], rd_e}, 32'h1);
        $display("Test registers done");
        repeat (6) @(posedge pclk);
        count_ale(60);
        check(c, 10);
        check(32'(lat_oe), 1);
        dbl <= 1'b1;
        repeat (6) @(posedge pclk);
        count_ale(60);
        check(c, 20);
        dbl <= 1'b0;
        apb(1, EBC_AUX_ADDR, 32'h01);
        repeat (6) @(posedge pclk);
        count_ale(60);
        check(c, 0);
        check(32'(lat_oe), 0);
        check(32'(pins.ale_pu), 1);
        for (int k = 0; k < 2; k++) begin
            cread <= (k == 0);
            efetch <= (k == 1);
            count_ale(30);
            check(32'(c != 0), 1);
        end
        cread <= 1'b0;
        efetch <= 1'b0;
        $display("Test latch strobe done");
        for (int s = 0; s < 4; s++) begin
            apb(1, EBC_AUX_ADDR, 32'((s << 2) | ((s == 3) ? 32'h20 : 32'h0)));
            move(16'(256 * (s + 1) - 1), s[0]);
            check(ni, 1);
            check(ne + nl, 0);
            move(16'(256 * (s + 1)), s[0]);
            check(ne, 1);
            check(nl, (s == 3) ? 30 : 6);
        end
        apb(1, EBC_AUX_ADDR, 32'h02);
        move(16'h0000, 1'b0);
        check(ne, 1);
        check(nl, 6);
        apb(1, EBC_AUX_ADDR, 32'h0);
        sec_inh <= 1'b1;
        move(16'h0000, 1'b1);
        check(ne, 1);
        sec_inh <= 1'b0;
        move(16'h0000, 1'b1);
        check(ni, 1);
        $display("Test data moves done");
        reset_pin <= 1'b1;
        emu_req <= 1'b1;
        repeat (4) @(posedge pclk);
        reset_pin <= 1'b0;
        repeat (3) @(posedge pclk);
        emu_req <= 1'b0;
        check(32'(emu), 1);
        repeat (5) @(posedge pclk);
        check(32'(emu), 1);
        check(32'(pins), 32'hff);
        reset_pin <= 1'b1;
        repeat (4) @(posedge pclk);
        reset_pin <= 1'b0;
        repeat (3) @(posedge pclk);
        check(32'(emu), 0);
        $display("Test emulation done");
        sec_ext <= 1'b1;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, EBC_AUX_ADDR, 32'h0);
        check(rd_d, 32'h02);
        $display("Test security default done");
        conclude();
    end
endmodule
